// >>> core/csp_ctrl.sv
// Purpose: Configuration array access, security bit and register preload.
// Assumes: Programmer requests are synchronous to clk_i, one cycle each.
// Notes:   Preload values arrive as levels from the output pins.
//
// Function
// - Preload loads chosen state when unsecured.
// - Illegal preloaded states accepted, then clock normally.
// - Secured readback returns erased value always.
// - Secured device ignores preload attempts.
// - Security clears only with full erase or reset.
// - Programming erases old pattern first.
// - Erased cell selects one path, programmed zero.
// - Macrocell registers reset to low.
`timescale 1ns/1ns
`include "csp_defs.svh"
module csp_ctrl
	import csp_pkg::*;
(
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    arst_n_i,
	// Programmer requests
	input  wire csp_req_t                req_i,
	output logic [`CSP_DATA_W-1:0]       rd_data_o,
	output logic                         rd_valid_o,
	output logic                         busy_o,
	output logic                         secured_o,
	// Pins and register array
	input  wire logic [`CSP_MC_N-1:0]    pin_i,
	input  wire logic [`CSP_MC_N-1:0]    next_state_i,
	output logic [`CSP_MC_N-1:0]         mc_q_o,
	output logic [`CSP_DEPTH-1:0]        mux_sel_o
);

	typedef enum logic {ST_IDLE, ST_ERASE} csp_state_t;

	////////////////////////////////////////////////////////////////////////////////
	logic [`CSP_DATA_W-1:0] cell_r [`CSP_DEPTH];
	logic                   sec_r;
	csp_state_t             state_r;
	logic [`CSP_ADDR_W-1:0] ptr_r;
	logic [`CSP_DATA_W-1:0] pend_data_r;
	logic [`CSP_ADDR_W-1:0] pend_addr_r;
	logic                   pend_r;
	logic [`CSP_MC_N-1:0]   pin_s1_r;
	logic [`CSP_MC_N-1:0]   pin_s2_r;
	logic                   idle;
	logic                   wipe;

	assign idle = (state_r == ST_IDLE);
	assign busy_o = !idle;
	assign secured_o = sec_r;
	// Whole-array wipe and reset are the only paths that may clear the security bit.
	assign wipe = idle && (req_i.cmd == CSP_CMD_ERASE || req_i.cmd == CSP_CMD_PROG);

	////////////////////////////////////////////////////////////////////////////////
	// Erase walks the array one word a cycle; a pending program word lands on the last step.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_r     <= ST_IDLE;
			ptr_r       <= '0;
			pend_r      <= 1'b0;
			pend_addr_r <= '0;
			pend_data_r <= '0;
		end else if (idle) begin
			if (wipe) begin
				state_r     <= ST_ERASE;
				ptr_r       <= '0;
				pend_r      <= (req_i.cmd == CSP_CMD_PROG);
				pend_addr_r <= req_i.addr;
				pend_data_r <= req_i.data;
			end
		end else if (ptr_r == `CSP_ADDR_W'(`CSP_DEPTH-1)) begin
			state_r <= ST_IDLE;
			pend_r  <= 1'b0;
		end else begin
			ptr_r <= ptr_r + `CSP_ADDR_W'(1);
		end
	end

	generate
		for (genvar i = 0; i < `CSP_DEPTH; i++) begin : g_cell
			always_ff @(posedge clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					cell_r[i] <= `CSP_ERASED_WORD;
				end else if (!idle && ptr_r == `CSP_ADDR_W'(`CSP_DEPTH-1) && pend_r
						&& pend_addr_r == `CSP_ADDR_W'(i)) begin
					// The pending word wins over the last wipe step, so the top cell can be programmed.
					cell_r[i] <= pend_data_r;
				end else if (!idle && ptr_r == `CSP_ADDR_W'(i)) begin
					cell_r[i] <= `CSP_ERASED_WORD;
				end
			end
			// Erased cell pulls its control high; programmed cell ties it low.
			assign mux_sel_o[i] = cell_r[i][`CSP_SEL_BIT];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Security bit: set by its own command, cleared only by the whole wipe or by reset.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sec_r <= `CSP_SEC_ERASED;
		end else if (wipe) begin
			sec_r <= `CSP_SEC_ERASED;
		end else if (idle && req_i.cmd == CSP_CMD_SECURE) begin
			sec_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_data_o  <= '0;
			rd_valid_o <= 1'b0;
		end else begin
			rd_valid_o <= idle && req_i.cmd == CSP_CMD_READ;
			if (idle && req_i.cmd == CSP_CMD_READ) begin
				rd_data_o <= sec_r ? `CSP_ERASED_WORD : cell_r[req_i.addr];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin levels are asynchronous to clk_i, so they are synchronised first.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
		end else begin
			pin_s1_r <= pin_i;
			pin_s2_r <= pin_s1_r;
		end
	end

	// No legality check: any state loads, and the next edge clocks it onward.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mc_q_o <= `CSP_MC_RESET;
		end else if (idle && req_i.cmd == CSP_CMD_PRELOAD && !sec_r) begin
			mc_q_o <= pin_s2_r;
		end else if (idle && req_i.cmd == CSP_CMD_PRELOAD) begin
			mc_q_o <= mc_q_o;
		end else begin
			mc_q_o <= next_state_i;
		end
	end

endmodule

// >>> core/csp_defs.svh
// Purpose: Constants for the configuration array and preload controller.
// Assumes: A small cell array and ten macrocell registers.
// Notes:   An erased cell reads as one.
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH
`define CSP_ADDR_W      4
`define CSP_DATA_W      8
`define CSP_DEPTH       16
`define CSP_MC_N        10
`define CSP_ERASED_WORD 8'hff
`define CSP_MC_RESET    10'h000
`define CSP_SEC_ERASED  1'b0
`define CSP_SEL_BIT     0
`endif

// >>> core/csp_pkg.sv
// Purpose: Types for the configuration array and preload controller.
// Assumes: The defines header is present.
// Notes:   Commands come in as one packed request.
`include "csp_defs.svh"
package csp_pkg;
	typedef enum logic [2:0] {
		CSP_CMD_NONE,
		CSP_CMD_READ,
		CSP_CMD_PROG,
		CSP_CMD_SECURE,
		CSP_CMD_ERASE,
		CSP_CMD_PRELOAD
	} csp_cmd_t;
	typedef struct packed {
		csp_cmd_t                 cmd;
		logic [`CSP_ADDR_W-1:0]   addr;
		logic [`CSP_DATA_W-1:0]   data;
	} csp_req_t;
endpackage

// >>> tb/csp_ctrl_props.sv
// Purpose: Port checker.
// Assumes: One clock.
// Notes:   Preload check needs pins steady for three edges.
`timescale 1ns/1ns
module csp_ctrl_props import csp_pkg::*; (
	input wire logic clk_i, arst_n_i, input wire csp_req_t req_i,
	input wire logic [7:0] rd_data_o, input wire logic rd_valid_o, busy_o, secured_o,
	input wire logic [9:0] pin_i, next_state_i, mc_q_o, input wire logic [15:0] mux_sel_o);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	wire rd = !busy_o && req_i.cmd == CSP_CMD_READ;
	wire pl = !busy_o && req_i.cmd == CSP_CMD_PRELOAD;
	wire wr = !busy_o && req_i.cmd inside {CSP_CMD_PROG, CSP_CMD_ERASE};
	a_read_pulse: assert property (rd |=> rd_valid_o) else $error("pulse");
	a_secret_read: assert property (rd && secured_o |=> rd_data_o == 8'hff) else $error("leak");
	a_preload_drop: assert property (pl && secured_o |=> $stable(mc_q_o)) else $error("drop");
	a_preload_take: assert property (pl && !secured_o && $stable(pin_i)
		&& $past(pin_i) == $past(pin_i, 2) |=> mc_q_o == $past(pin_i)) else $error("load");
	a_free_step: assert property (req_i.cmd != CSP_CMD_PRELOAD
		|=> mc_q_o == $past(next_state_i)) else $error("step");
	a_walk_len: assert property (wr |=> busy_o [*8] ##1 busy_o [*8] ##1 !busy_o)
		else $error("walk");
	a_wipe_clear: assert property (wr |=> !secured_o) else $error("sec");
	a_clear_cause: assert property ($fell(secured_o) |-> $past(wr)) else $error("clr");
	c_read: cover property (rd && secured_o);
	c_load: cover property (pl && !secured_o);
	c_walk: cover property (wr);
endmodule
bind csp_ctrl csp_ctrl_props csp_ctrl_props_inst (.*);

// >>> tb/csp_user_fsm.sv
// Purpose: User next-state logic.
// Assumes: Counts up.
// Notes:   Makes recovery from a preloaded state visible.
`timescale 1ns/1ns
module csp_user_fsm (
	input  wire logic [9:0] mc_q_i,
	output logic      [9:0] next_o
);
	assign next_o = mc_q_i + 10'h001;
endmodule

// >>> tb/testbench.sv
// Purpose: Bench for the controller.
// Assumes: Model array in ints.
// Notes:   Preload pins held three edges.
`timescale 1ns/1ns
module testbench import csp_pkg::*; ;
	logic clk_i = 1'b0, arst_n_i = 1'b0;
	csp_req_t req_i = '0;
	logic [9:0] pin_i = '0, v;
	wire [9:0] nx, mc_q_o;
	wire [7:0] rd_data_o;
	wire rd_valid_o, busy_o, secured_o;
	wire [15:0] mux_sel_o;
	int n_errors = 0, comparisons = 0, seed = 70, mem[16], a, d;
	csp_ctrl csp_ctrl_inst (.clk_i, .arst_n_i, .req_i, .rd_data_o, .rd_valid_o, .busy_o,
		.secured_o, .pin_i, .next_state_i(nx), .mc_q_o, .mux_sel_o);
	csp_user_fsm csp_user_fsm_inst (.mc_q_i(mc_q_o), .next_o(nx));
	initial forever #50 clk_i = ~clk_i;
	task chk(logic [15:0] g, e);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: %h not %h", $time, g, e);
		end
	endtask
	task results;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task op(csp_cmd_t c, int ad, int dt);
		@(posedge clk_i) req_i <= '{c, ad[3:0], dt[7:0]};
		@(posedge clk_i) req_i <= '0;
		#1;
	endtask
	// Bounded wait so a stuck erase walk ends the run.
	task wt;
		for (int i = 0; busy_o !== 1'b0; i++) begin
			if (i > 40) begin
				n_errors++;
				results;
			end
			@(posedge clk_i) #1;
		end
	endtask
	task rd(int ad, int e);
		op(CSP_CMD_READ, ad, 0);
		chk(rd_valid_o, 1);
		chk(rd_data_o, e);
	endtask
	function logic [15:0] sel;
		for (int i = 0; i < 16; i++) sel[i] = mem[i][0];
	endfunction
	initial begin
		for (int i = 0; i < 16; i++) mem[i] = 255;
		repeat (10) @(posedge clk_i);
		arst_n_i <= 1'b1;
		#1 chk(mc_q_o, 0);
		chk(mux_sel_o, sel());
		a = $unsigned($random(seed)) % 16;
		d = $random(seed) & 254;
		op(CSP_CMD_PROG, a, d); wt;
		mem[a] = d;
		chk(mux_sel_o, sel());
		rd(a, d);
		rd((a + 1) % 16, 255);
		@(posedge clk_i) pin_i <= $random(seed);
		repeat (3) @(posedge clk_i);
		op(CSP_CMD_PRELOAD, 0, 0); chk(mc_q_o, pin_i);
		@(posedge clk_i) #1 chk(mc_q_o, {6'h00, pin_i + 10'h001});
		op(CSP_CMD_SECURE, 0, 0); chk(secured_o, 1);
		rd(a, 255);
		v = mc_q_o;
		op(CSP_CMD_PRELOAD, 0, 0); chk(mc_q_o, {6'h00, v + 10'h001});
		op(CSP_CMD_ERASE, 0, 0); wt;
		mem[a] = 255;
		chk(secured_o, 0);
		chk(mux_sel_o, sel());
		rd(a, 255);
		op(CSP_CMD_PRELOAD, 0, 0); chk(mc_q_o, pin_i);
		@(posedge clk_i) arst_n_i <= 1'b0;
		#1 chk(mc_q_o, 0);
		results;
	end
endmodule
